// ===== playback_dsp_pkg.sv
// Constants for the playback processing chain: register map, fields, resets, timing.
package playback_dsp_pkg;
  // Byte offsets of the word registers.
  localparam logic [7:0] ADDR_TIMER = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_REF = 8'h08;
  localparam logic [7:0] ADDR_LVLVOL = 8'h0c;
  localparam logic [7:0] ADDR_OUTVOL = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_COEF0 = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h58;
  localparam int COEF_WORDS = 15;
  // Timer register fields.
  localparam int TM_WAIT_LSB = 0;
  localparam int TM_ZCT_LSB = 3;
  localparam int TM_RAMP_BIT = 5;
  // Mode register fields.
  localparam int MD_RGAIN_LO_BIT = 0;
  localparam int MD_RGAIN_HI_BIT = 7;
  localparam int MD_LMAT_LSB = 2;
  localparam int MD_ZCOFF_BIT = 4;
  localparam int MD_ALCEN_BIT = 5;
  localparam int MD_FRN_BIT = 6;
  // Control register fields.
  localparam int CT_VCM_BIT = 0;
  localparam int CT_DEM_LSB = 1;
  localparam int CT_OUTLINK_BIT = 3;
  localparam int CT_LVLLINK_BIT = 4;
  localparam int CT_SOFT_MUTE_BIT = 5;
  localparam int CT_DACHP_BIT = 6;
  localparam int CT_MINHP_BIT = 7;
  localparam int CT_HPMONO_BIT = 8;
  localparam int CT_HPGAIN_BIT = 9;
  localparam int CT_SEPEN_BIT = 10;
  localparam int CT_SEPTYPE_BIT = 11;
  localparam int CT_GCEN_BIT = 12;
  localparam int CT_HPFEN_BIT = 13;
  localparam int CT_LPFEN_BIT = 14;
  localparam int CT_EQEN_LSB = 15;
  localparam int EQ_BANDS = 5;
  // Reset values.
  localparam logic [7:0] REF_RESET = 8'he1;
  localparam logic [7:0] LVLVOL_RESET = 8'he1;
  localparam logic [7:0] OUTVOL_RESET = 8'h18;
  localparam logic [1:0] DEM_RESET = 2'h1;
  localparam logic [31:0] COEF_RESET = 32'h0000_0000;
  // Coefficient word masks: 14+14, 16+14, 16, 14+14, 14+14, then 16+16 and 16 per band.
  localparam logic [31:0] MASK_14_14 = 32'h3fff_3fff;
  localparam logic [31:0] MASK_16_14 = 32'h3fff_ffff;
  localparam logic [31:0] MASK_16 = 32'h0000_ffff;
  localparam logic [31:0] MASK_16_16 = 32'hffff_ffff;
  // Volume ramp: full scale travel of 255 codes over the selected time in samples.
  localparam int RAMP_SLOW_FS = 1061;
  localparam int RAMP_FAST_FS = 256;
  localparam int VOL_SPAN = 255;
  localparam logic [3:0] RAMP_SLOW_STEP = 4'(RAMP_SLOW_FS / VOL_SPAN);
  localparam logic [3:0] RAMP_FAST_STEP = 4'(RAMP_FAST_FS / VOL_SPAN);
  localparam logic [8:0] MUTE_UNITY = 9'h100;
  localparam int COEF_FRAC = 14;
endpackage : playback_dsp_pkg

// ===== playback_dsp_path_control.sv
// Playback processing chain with its AHB-Lite register file.
`timescale 1ns/1ps
`default_nettype none
module playback_dsp_path_control (
  input wire logic clock, // 125 MHz system clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic powerDownPinN, // Power-down pin, low clears every field.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write flag.
  input wire logic [2:0] hsize, // AHB transfer size.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  output logic [31:0] hrdata, // AHB read data.
  input wire logic sampleValid, // One-cycle strobe at the sample rate.
  input wire logic signed [23:0] pcmLeft, // Left input sample.
  input wire logic signed [23:0] pcmRight, // Right input sample.
  output logic outValid, // Pulse when the headphone samples update.
  output logic signed [23:0] hpLeft, // Left sample into the headphone path.
  output logic signed [23:0] hpRight, // Right sample into the headphone path.
  output logic [1:0] recovery_gain_step, // Recovery gain step.
  output logic [1:0] limiter_atten_step, // Limiter attenuation step.
  output logic limiter_zero_cross_off, // High bypasses limiter zero crossing.
  output logic auto_level_en, // Level control enable.
  output logic [7:0] recovery_reference_level, // Recovery reference code.
  output logic [2:0] recovery_wait_period, // Recovery wait code.
  output logic [1:0] zero_cross_timeout, // Zero-cross timeout code.
  output logic fast_recovery_off, // High inhibits fast recovery.
  output logic [7:0] lvlVolLeftEff, // Level volume in force on the left.
  output logic [7:0] lvlVolRightEff, // Level volume in force on the right.
  output logic [7:0] outVolLeftCur, // Ramped output volume, left.
  output logic [7:0] outVolRightCur, // Ramped output volume, right.
  output logic hpVcmSel, // Headphone common voltage select.
  output logic [1:0] deemphasis_sel, // De-emphasis frequency code.
  output logic dac_to_hp_switch, // DAC to headphone switch.
  output logic mono_in_to_hp_switch, // Mono input to headphone switch.
  output logic hp_gain_sel // Headphone gain select.
);

  // Raw register fields.
  logic [2:0] waitPeriod_r; // Recovery wait field.
  logic [1:0] zcTimeout_r; // Zero-cross timeout field.
  logic volRampSel_r; // Ramp time select.
  logic [31:0] mode_r; // Level-control mode word, low eight bits kept.
  logic [7:0] refLevel_r; // Recovery reference.
  logic [7:0] level_ctrl_vol_left_r; // Level volume, left field.
  logic [7:0] level_ctrl_vol_right_r; // Level volume, right field.
  logic [7:0] out_vol_left_r; // Output volume, left field.
  logic [7:0] out_vol_right_r; // Output volume, right field.
  logic [31:0] ctrl_r; // Control word, only defined bits kept.
  logic [31:0] coef_r [playback_dsp_pkg::COEF_WORDS]; // Coefficient words.
  // Bus state.
  logic wrPend_r; // A write data phase is due.
  logic [7:0] wrAddr_r; // Address of the pending write.
  logic clearAll; // Reset or power-down pin asserted.
  logic addrPhase; // Valid transfer taken this cycle.
  logic [31:0] readMux; // Combinational read data.
  logic [3:0] coefIdx; // Coefficient index of the read address.
  logic [3:0] wrIdx; // Coefficient index of the write address.
  // Datapath state.
  logic signed [23:0] stState_r [2][9]; // Previous output of each stage.
  logic signed [23:0] chainOut [2]; // Chain result per channel.
  logic signed [15:0] cA [9]; // First coefficient per stage.
  logic signed [15:0] cB [9]; // Feedback coefficient per stage.
  logic signed [15:0] cC [9]; // Third coefficient per stage.
  logic [8:0] stageEn; // Stage enables.
  logic [8:0] stageNeg; // Stages with subtracted feedback.
  logic [3:0] rampCnt_r; // Samples since the last ramp step.
  logic [8:0] muteGain_r; // Soft mute gain, 256 is unity.
  logic rampTick; // Ramp steps on this sample.
  logic [7:0] outVolRightTgt; // Right target after linking.

  assign clearAll = reset || !powerDownPinN;
  assign addrPhase = hsel && htrans[1] && hready;

  // Sign-extends a 14-bit coefficient to the common width.
  function automatic logic signed [15:0] ext14(input logic [13:0] v);
    ext14 = {{2{v[13]}}, v};
  endfunction

  // Maps a byte address onto a coefficient word index.
  function automatic logic [3:0] coefIndex(input logic [7:0] a);
    logic [7:0] d;
    d = a - playback_dsp_pkg::ADDR_COEF0;
    coefIndex = d[5:2];
  endfunction

  // Mask of implemented coefficient bits per word.
  function automatic logic [31:0] coefMask(input logic [3:0] i);
    coefMask = playback_dsp_pkg::MASK_16_16;
    case (i)
      4'h0, 4'h3, 4'h4: coefMask = playback_dsp_pkg::MASK_14_14;
      4'h1: coefMask = playback_dsp_pkg::MASK_16_14;
      4'h2, 4'h6, 4'h8, 4'ha, 4'hc, 4'he: coefMask = playback_dsp_pkg::MASK_16;
      default: coefMask = playback_dsp_pkg::MASK_16_16;
    endcase
  endfunction

  // True when the address hits the coefficient window.
  function automatic logic isCoef(input logic [7:0] a);
    isCoef = (a >= playback_dsp_pkg::ADDR_COEF0)
             && (a < playback_dsp_pkg::ADDR_COEF0 + 8'(4 * playback_dsp_pkg::COEF_WORDS))
             && (a[1:0] == 2'h0);
  endfunction

  // One filter section: a*x + c*x plus or minus b*previous output, Q2.14.
  function automatic logic signed [23:0] section(input logic signed [23:0] x,
      input logic signed [23:0] st, input logic signed [15:0] a,
      input logic signed [15:0] b, input logic signed [15:0] c, input logic neg);
    logic signed [41:0] fb;
    logic signed [41:0] acc;
    fb = 42'(st * b);
    acc = 42'(x * a) + 42'(x * c) + (neg ? -fb : fb);
    section = acc[37:14];
  endfunction

  assign coefIdx = coefIndex(haddr[7:0]);
  assign wrIdx = coefIndex(wrAddr_r);

  // Bus handshake: zero wait states, response always OKAY.
  always_ff @(posedge clock) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wrPend_r <= addrPhase && hwrite;
        wrAddr_r <= haddr[7:0];
      end
    end
  end

  // Read data is captured at the address phase so it stands for the data phase.
  always_comb begin
    readMux = 32'h0000_0000;
    case (haddr[7:0])
      playback_dsp_pkg::ADDR_TIMER: begin
        readMux[playback_dsp_pkg::TM_WAIT_LSB +: 3] = waitPeriod_r;
        readMux[playback_dsp_pkg::TM_ZCT_LSB +: 2] = zcTimeout_r;
        readMux[playback_dsp_pkg::TM_RAMP_BIT] = volRampSel_r;
      end
      playback_dsp_pkg::ADDR_MODE: readMux = mode_r;
      playback_dsp_pkg::ADDR_REF: readMux[7:0] = refLevel_r;
      playback_dsp_pkg::ADDR_LVLVOL: readMux[15:0] = {level_ctrl_vol_right_r, level_ctrl_vol_left_r};
      playback_dsp_pkg::ADDR_OUTVOL: readMux[15:0] = {out_vol_right_r, out_vol_left_r};
      playback_dsp_pkg::ADDR_CTRL: readMux = ctrl_r;
      playback_dsp_pkg::ADDR_STATUS: readMux[24:0] = {muteGain_r, outVolRightCur, outVolLeftCur};
      default: begin
        if (isCoef(haddr[7:0])) begin
          readMux = coef_r[coefIdx];
        end
      end
    endcase
  end

  // Read data register; unmapped addresses read as zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= readMux;
    end
  end

  // Scalar configuration writes. The power-down pin clears them like reset.
  always_ff @(posedge clock) begin
    if (clearAll) begin
      waitPeriod_r <= 3'h0;
      zcTimeout_r <= 2'h0;
      volRampSel_r <= 1'b0;
      mode_r <= 32'h0000_0000;
      refLevel_r <= playback_dsp_pkg::REF_RESET;
      level_ctrl_vol_left_r <= playback_dsp_pkg::LVLVOL_RESET;
      level_ctrl_vol_right_r <= playback_dsp_pkg::LVLVOL_RESET;
      out_vol_left_r <= playback_dsp_pkg::OUTVOL_RESET;
      out_vol_right_r <= playback_dsp_pkg::OUTVOL_RESET;
      ctrl_r <= {29'h0, playback_dsp_pkg::DEM_RESET, 1'b0}
                | (32'h1 << playback_dsp_pkg::CT_OUTLINK_BIT)
                | (32'h1 << playback_dsp_pkg::CT_LVLLINK_BIT);
    end else if (wrPend_r) begin
      case (wrAddr_r)
        playback_dsp_pkg::ADDR_TIMER: begin
          waitPeriod_r <= hwdata[playback_dsp_pkg::TM_WAIT_LSB +: 3];
          zcTimeout_r <= hwdata[playback_dsp_pkg::TM_ZCT_LSB +: 2];
          volRampSel_r <= hwdata[playback_dsp_pkg::TM_RAMP_BIT];
        end
        playback_dsp_pkg::ADDR_MODE: mode_r <= hwdata & 32'h0000_00ff;
        playback_dsp_pkg::ADDR_REF: refLevel_r <= hwdata[7:0];
        // Writes to a left field never copy into the right field, even when linked.
        playback_dsp_pkg::ADDR_LVLVOL: begin
          level_ctrl_vol_left_r <= hwdata[7:0];
          level_ctrl_vol_right_r <= hwdata[15:8];
        end
        playback_dsp_pkg::ADDR_OUTVOL: begin
          out_vol_left_r <= hwdata[7:0];
          out_vol_right_r <= hwdata[15:8];
        end
        playback_dsp_pkg::ADDR_CTRL: ctrl_r <= hwdata & 32'h000f_ffff;
        default: begin
        end
      endcase
    end
  end

  // Coefficient words, one flip-flop word per entry, masked to their widths.
  genvar gi;
  generate
    for (gi = 0; gi < playback_dsp_pkg::COEF_WORDS; gi++) begin : gCoef
      always_ff @(posedge clock) begin
        if (clearAll) begin
          coef_r[gi] <= playback_dsp_pkg::COEF_RESET;
        end else if (wrPend_r && isCoef(wrAddr_r) && (wrIdx == 4'(gi))) begin
          coef_r[gi] <= hwdata & coefMask(4'(gi));
        end
      end
    end
  endgenerate

  // Stage parameters: separation, gain compensation, high-pass, low-pass, five bands.
  always_comb begin
    stageEn = {ctrl_r[playback_dsp_pkg::CT_EQEN_LSB +: playback_dsp_pkg::EQ_BANDS],
               ctrl_r[playback_dsp_pkg::CT_LPFEN_BIT], ctrl_r[playback_dsp_pkg::CT_HPFEN_BIT],
               ctrl_r[playback_dsp_pkg::CT_GCEN_BIT], ctrl_r[playback_dsp_pkg::CT_SEPEN_BIT]};
    stageNeg = 9'h004;
    stageNeg[0] = !ctrl_r[playback_dsp_pkg::CT_SEPTYPE_BIT];
    cA[0] = ext14(coef_r[0][13:0]);
    cB[0] = ext14(coef_r[0][29:16]);
    cC[0] = 16'sh0000;
    cA[1] = coef_r[1][15:0];
    cB[1] = ext14(coef_r[1][29:16]);
    cC[1] = coef_r[2][15:0];
    cA[2] = ext14(coef_r[3][13:0]);
    cB[2] = ext14(coef_r[3][29:16]);
    cC[2] = 16'sh0000;
    cA[3] = ext14(coef_r[4][13:0]);
    cB[3] = ext14(coef_r[4][29:16]);
    cC[3] = 16'sh0000;
    for (int k = 0; k < playback_dsp_pkg::EQ_BANDS; k++) begin
      cA[4 + k] = coef_r[5 + 2 * k][15:0];
      cB[4 + k] = coef_r[5 + 2 * k][31:16];
      cC[4 + k] = coef_r[6 + 2 * k][15:0];
    end
  end

  // Per-channel filter chain; a disabled stage passes its input unchanged.
  generate
    for (gi = 0; gi < 2; gi++) begin : gChan
      logic signed [23:0] x [10];
      always_comb begin
        x[0] = (gi == 0) ? pcmLeft : pcmRight;
        for (int k = 0; k < 9; k++) begin
          x[k + 1] = stageEn[k] ? section(x[k], stState_r[gi][k], cA[k], cB[k], cC[k],
                                          stageNeg[k]) : x[k];
        end
        chainOut[gi] = x[9];
      end
      always_ff @(posedge clock) begin
        if (clearAll) begin
          for (int k = 0; k < 9; k++) begin
            stState_r[gi][k] <= 24'sh000000;
          end
        end else if (sampleValid) begin
          for (int k = 0; k < 9; k++) begin
            stState_r[gi][k] <= x[k + 1];
          end
        end
      end
    end
  endgenerate

  assign rampTick = sampleValid && (rampCnt_r >= (volRampSel_r ? playback_dsp_pkg::RAMP_FAST_STEP
                                                  : playback_dsp_pkg::RAMP_SLOW_STEP) - 4'h1);
  assign outVolRightTgt = ctrl_r[playback_dsp_pkg::CT_OUTLINK_BIT] ? out_vol_left_r
                          : out_vol_right_r;

  // Output volume and soft mute both move one step per ramp tick, so no jump is audible.
  always_ff @(posedge clock) begin
    if (clearAll) begin
      rampCnt_r <= 4'h0;
      outVolLeftCur <= playback_dsp_pkg::OUTVOL_RESET;
      outVolRightCur <= playback_dsp_pkg::OUTVOL_RESET;
      muteGain_r <= playback_dsp_pkg::MUTE_UNITY;
    end else if (sampleValid) begin
      rampCnt_r <= rampTick ? 4'h0 : rampCnt_r + 4'h1;
      if (rampTick) begin
        if (outVolLeftCur < out_vol_left_r) outVolLeftCur <= outVolLeftCur + 8'h01;
        else if (outVolLeftCur > out_vol_left_r) outVolLeftCur <= outVolLeftCur - 8'h01;
        if (outVolRightCur < outVolRightTgt) outVolRightCur <= outVolRightCur + 8'h01;
        else if (outVolRightCur > outVolRightTgt) outVolRightCur <= outVolRightCur - 8'h01;
        if (ctrl_r[playback_dsp_pkg::CT_SOFT_MUTE_BIT] && muteGain_r != 9'h000) begin
          muteGain_r <= muteGain_r - 9'h001;
        end else if (!ctrl_r[playback_dsp_pkg::CT_SOFT_MUTE_BIT] &&
                     muteGain_r != playback_dsp_pkg::MUTE_UNITY) begin
          muteGain_r <= muteGain_r + 9'h001;
        end
      end
    end
  end

  // Headphone samples: optional mono mix, soft-mute gain, then the DAC switch.
  always_ff @(posedge clock) begin
    logic signed [24:0] mono;
    logic signed [33:0] pl;
    logic signed [33:0] pr;
    mono = 25'(chainOut[0]) + 25'(chainOut[1]);
    if (clearAll) begin
      outValid <= 1'b0;
      hpLeft <= 24'sh000000;
      hpRight <= 24'sh000000;
    end else begin
      outValid <= sampleValid;
      if (sampleValid) begin
        if (ctrl_r[playback_dsp_pkg::CT_HPMONO_BIT]) begin
          pl = 34'(mono[24:1] * $signed({1'b0, muteGain_r}));
          pr = pl;
        end else begin
          pl = 34'(chainOut[0] * $signed({1'b0, muteGain_r}));
          pr = 34'(chainOut[1] * $signed({1'b0, muteGain_r}));
        end
        hpLeft <= ctrl_r[playback_dsp_pkg::CT_DACHP_BIT] ? pl[31:8] : 24'sh000000;
        hpRight <= ctrl_r[playback_dsp_pkg::CT_DACHP_BIT] ? pr[31:8] : 24'sh000000;
      end
    end
  end

  // Field outputs, registered copies of the register contents.
  always_ff @(posedge clock) begin
    if (clearAll) begin
      recovery_gain_step <= 2'h0;
      limiter_atten_step <= 2'h0;
      limiter_zero_cross_off <= 1'b0;
      auto_level_en <= 1'b0;
      recovery_reference_level <= playback_dsp_pkg::REF_RESET;
      recovery_wait_period <= 3'h0;
      zero_cross_timeout <= 2'h0;
      fast_recovery_off <= 1'b0;
      lvlVolLeftEff <= playback_dsp_pkg::LVLVOL_RESET;
      lvlVolRightEff <= playback_dsp_pkg::LVLVOL_RESET;
      hpVcmSel <= 1'b0;
      deemphasis_sel <= playback_dsp_pkg::DEM_RESET;
      dac_to_hp_switch <= 1'b0;
      mono_in_to_hp_switch <= 1'b0;
      hp_gain_sel <= 1'b0;
    end else begin
      recovery_gain_step <= {mode_r[playback_dsp_pkg::MD_RGAIN_HI_BIT],
                             mode_r[playback_dsp_pkg::MD_RGAIN_LO_BIT]};
      limiter_atten_step <= mode_r[playback_dsp_pkg::MD_LMAT_LSB +: 2];
      limiter_zero_cross_off <= mode_r[playback_dsp_pkg::MD_ZCOFF_BIT];
      auto_level_en <= mode_r[playback_dsp_pkg::MD_ALCEN_BIT];
      recovery_reference_level <= refLevel_r;
      recovery_wait_period <= waitPeriod_r;
      zero_cross_timeout <= zcTimeout_r;
      fast_recovery_off <= mode_r[playback_dsp_pkg::MD_FRN_BIT];
      lvlVolLeftEff <= level_ctrl_vol_left_r;
      lvlVolRightEff <= ctrl_r[playback_dsp_pkg::CT_LVLLINK_BIT] ? level_ctrl_vol_left_r
                        : level_ctrl_vol_right_r;
      hpVcmSel <= ctrl_r[playback_dsp_pkg::CT_VCM_BIT];
      deemphasis_sel <= ctrl_r[playback_dsp_pkg::CT_DEM_LSB +: 2];
      dac_to_hp_switch <= ctrl_r[playback_dsp_pkg::CT_DACHP_BIT];
      mono_in_to_hp_switch <= ctrl_r[playback_dsp_pkg::CT_MINHP_BIT];
      hp_gain_sel <= ctrl_r[playback_dsp_pkg::CT_HPGAIN_BIT];
    end
  end

endmodule // playback_dsp_path_control
`default_nettype wire

// ===== playback_dsp_path_control_asserts.sv
// Checker for the playback chain's bus, stream and field ports.
`timescale 1ns/1ps
`default_nettype none
module playback_dsp_checker (
  input wire logic clock, // Clock.
  input wire logic reset, // Sync reset.
  input wire logic powerDownPinN, // Power-down pin.
  input wire logic hsel, // Select.
  input wire logic [31:0] haddr, // Address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write flag.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  input wire logic hreadyout, // Slave ready.
  input wire logic hresp, // Response.
  input wire logic sampleValid, // Sample strobe.
  input wire logic outValid, // Output strobe.
  input wire logic [1:0] recovery_gain_step, // Gain step pin.
  input wire logic auto_level_en, // Level control pin.
  input wire logic [7:0] recovery_reference_level, // Reference pin.
  input wire logic [1:0] deemphasis_sel, // De-emphasis pin.
  input wire logic dac_to_hp_switch, // Switch pin.
  input wire logic hp_gain_sel, // Gain pin.
  input wire logic [7:0] outVolLeftCur // Ramped volume.
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // A write address phase taken while the pin allows it.
  wire logic wrA = hsel && htrans[1] && hready && hwrite && powerDownPinN;
  chk_resp_okay: assert property (hresp == 1'b0) else $error("Response not OKAY.");
  chk_zero_wait: assert property (hreadyout) else $error("Wait state seen.");
  chk_pd_defaults: assert property (!powerDownPinN[*3] |-> recovery_reference_level == 8'he1
    && deemphasis_sel == 2'h1 && !auto_level_en && !dac_to_hp_switch) else $error("Not defaults.");
  chk_ref_write: assert property (wrA && haddr[7:0] == 8'h08 ##1 powerDownPinN[*2]
    |=> recovery_reference_level == $past(hwdata[7:0], 2)) else $error("Reference pin wrong.");
  chk_mode_write: assert property (wrA && haddr[7:0] == 8'h04 ##1 powerDownPinN[*2]
    |=> recovery_gain_step == {$past(hwdata[7], 2), $past(hwdata[0], 2)}
    && auto_level_en == $past(hwdata[5], 2)) else $error("Mode pins wrong.");
  chk_ctrl_write: assert property (wrA && haddr[7:0] == 8'h14 ##1 powerDownPinN[*2]
    |=> deemphasis_sel == $past(hwdata[2:1], 2) && dac_to_hp_switch == $past(hwdata[6], 2)
    && hp_gain_sel == $past(hwdata[9], 2)) else $error("Control pins wrong.");
  chk_out_pulse: assert property (powerDownPinN |=> outValid == $past(sampleValid))
    else $error("Output strobe wrong.");
  chk_ramp_step: assert property (powerDownPinN && $past(powerDownPinN) |->
    outVolLeftCur - $past(outVolLeftCur) inside {8'h00, 8'h01, 8'hff}) else $error("Ramp jump.");
  cov_sample: cover property (sampleValid);
  cov_ctrl: cover property (wrA && haddr[7:0] == 8'h14);
  cov_pd: cover property (!powerDownPinN[*3]);
endmodule // playback_dsp_checker
bind playback_dsp_path_control playback_dsp_checker chk_u (.clock(clock), .reset(reset),
  .powerDownPinN(powerDownPinN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sampleValid(sampleValid), .outValid(outValid), .recovery_gain_step(recovery_gain_step),
  .auto_level_en(auto_level_en), .recovery_reference_level(recovery_reference_level),
  .deemphasis_sel(deemphasis_sel), .dac_to_hp_switch(dac_to_hp_switch),
  .hp_gain_sel(hp_gain_sel), .outVolLeftCur(outVolLeftCur));
`default_nettype wire

// ===== host_ctrl_model.sv
// Host controller model: a single-transfer register bus master.
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
  input wire logic clock, // Clock.
  input wire logic hreadyout, // Slave ready, used as bus ready.
  input wire logic [31:0] hrdata, // Read data.
  output logic hsel, // Select.
  output logic [31:0] haddr, // Address.
  output logic [1:0] htrans, // Transfer type.
  output logic hwrite, // Write flag.
  output logic [2:0] hsize, // Word size only.
  output logic [31:0] hwdata // Write data.
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One word transfer; an idle cycle always follows, so reads never see stale writes.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd; // Released data must not look still valid.
  endtask
endmodule // host_ctrl_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the playback chain.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0; // 125 MHz clock.
  logic reset = 1'b1; // Sync reset.
  logic powerDownPinN = 1'b1; // Power-down pin.
  logic sampleValid = 1'b0; // Sample strobe.
  logic signed [23:0] pcmL = 24'sh0; // Left sample.
  logic signed [23:0] pcmR = 24'sh0; // Right sample.
  wire logic hsel, hwrite, hrdy, hresp, oV, vcm, mi, hg, zc, ae, fr, dac;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans, rg, la, zt, dem;
  wire logic [2:0] hsize, wp;
  wire logic [7:0] rl, lvL, lvR, ovL, ovR;
  wire logic signed [23:0] hpL, hpR;
  int err_count = 0; // Mismatches.
  int n_checks = 0; // Comparisons.
  int cycles = 0; // Timeout counter.
  logic [31:0] rv; // Last read word.
  logic [31:0] m5 [5] = '{32'h3fff3fff, 32'h3fffffff, 32'hffff, 32'h3fff3fff, 32'h3fff3fff};
  int fb [10] = '{10, 12, 13, 14, 15, 16, 17, 18, 19, 11}; // Filter enables, and the separation type bit last.
  always #4 clock = ~clock;
  host_ctrl_model host_u (.clock(clock), .hreadyout(hrdy), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  playback_dsp_path_control dut_u (.clock(clock), .reset(reset), .powerDownPinN(powerDownPinN),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .sampleValid(sampleValid), .pcmLeft(pcmL), .pcmRight(pcmR), .outValid(oV), .hpLeft(hpL),
    .hpRight(hpR), .recovery_gain_step(rg), .limiter_atten_step(la),
    .limiter_zero_cross_off(zc), .auto_level_en(ae), .recovery_reference_level(rl),
    .recovery_wait_period(wp), .zero_cross_timeout(zt), .fast_recovery_off(fr),
    .lvlVolLeftEff(lvL), .lvlVolRightEff(lvR), .outVolLeftCur(ovL), .outVolRightCur(ovR),
    .hpVcmSel(vcm), .deemphasis_sel(dem), .dac_to_hp_switch(dac), .mono_in_to_hp_switch(mi),
    .hp_gain_sel(hg));
  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rv);
    repeat (3) @(posedge clock); // Let the field pins follow.
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, rv);
    check(what, rv, exp);
  endtask
  // Sends n samples, two cycles apart, leaving the last result settled.
  task automatic smp(input logic [23:0] l, input logic [23:0] r, input int n);
    repeat (n) begin
      @(posedge clock);
      sampleValid <= 1'b1;
      pcmL <= l;
      pcmR <= r;
      @(posedge clock);
      sampleValid <= 1'b0;
      #1;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rdc("timer", 8'h00, 32'h0);
    rdc("mode", 8'h04, 32'h0);
    rdc("ref", 8'h08, 32'he1);
    rdc("lvlvol", 8'h0c, 32'he1e1);
    rdc("outvol", 8'h10, 32'h1818);
    rdc("ctrl", 8'h14, 32'h1a);
    check("pins", 32'({rg, la, zc, ae, fr, vcm, mi, hg, wp, zt, dem}), 32'h1);
    for (int i = 0; i < 15; i++) begin
      rdc("coef", 8'(8'h18 + 4 * i), 32'h0);
      wr(8'(8'h18 + 4 * i), 32'hffffffff);
      rdc("coef", 8'(8'h18 + 4 * i), i < 5 ? m5[i] : (i % 2 ? 32'hffffffff : 32'hffff));
    end
    wr(8'h5c, 32'hffffffff);
    rdc("unmapped", 8'h5c, 32'h0);
    wr(8'h04, 32'h80);
    check("gain step", 32'(rg), 32'h2);
    wr(8'h08, 32'h55);
    check("ref pin", 32'(rl), 32'h55);
    powerDownPinN <= 1'b0;
    repeat (3) @(posedge clock);
    powerDownPinN <= 1'b1;
    rdc("ref", 8'h08, 32'he1);
    rdc("coef", 8'h2c, 32'h0);
    wr(8'h0c, 32'h2010);
    check("lvl right", 32'(lvR), 32'h10);
    rdc("lvlvol", 8'h0c, 32'h2010);
    wr(8'h14, 32'h0a);
    check("lvl right", 32'(lvR), 32'h20);
    wr(8'h00, 32'h20);
    wr(8'h10, 32'h101a);
    smp(24'h0, 24'h0, 8);
    check("out right", 32'(ovR), 32'h1a);
    rdc("outvol", 8'h10, 32'h101a);
    wr(8'h14, 32'h42);
    smp(24'h1000, 24'h3000, 1);
    check("left", 32'(hpL), 32'h1000);
    check("right", 32'(hpR), 32'h3000);
    wr(8'h14, 32'h142); // Host side: mono is set with the DAC switch on.
    smp(24'h1000, 24'h3000, 1);
    check("mono", 32'(hpR), 32'h2000);
    foreach (fb[i]) begin
      wr(8'h14, 32'h42 | (32'h1 << fb[i]));
      smp(24'h1000, 24'h1000, 2);
      check("filter", 32'(hpL), fb[i] == 11 ? 32'h1000 : 32'h0);
    end
    wr(8'h14, 32'h62);
    smp(24'h1000, 24'h1000, 1);
    check("mute ramp", 32'(hpL != 24'sh0), 32'h1);
    smp(24'h1000, 24'h1000, 260);
    check("muted", 32'(hpL), 32'h0);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
